// ### rtl/eep_pkg.sv
// eep_pkg: constants and carrier types for the two-wire serial memory slave
// assumes: included before every design file that uses the slave
package eep_pkg;
	localparam int          EEP_MEM_BYTES   = 1024;
	localparam int          EEP_ADDR_W      = 10;
	localparam int          EEP_PAGE_BYTES  = 16;
	localparam int          EEP_PAGE_W      = 4;
	localparam logic [3:0]  EEP_TYPE_CODE   = 4'h5;   // arbitrary fixed type code
	localparam int          EEP_SYS_CLK_HZ  = 20_000_000;
	localparam int          EEP_WRITE_MS    = 10;
	localparam int          EEP_WRITE_CYC   = EEP_SYS_CLK_HZ / 1000 * EEP_WRITE_MS;
	localparam logic [EEP_ADDR_W-1:0] EEP_ADDR_RESET = 10'h000;

	// open-drain data pin as two signals
	typedef struct packed {
		logic sda_out;
		logic sda_oe;
	} eep_sda_drive_s;

	// a committed page handed from the link to the system domain
	typedef struct packed {
		logic [EEP_ADDR_W-1:0] base;
		logic [EEP_PAGE_BYTES-1:0] mask;
	} eep_commit_s;
endpackage

// ### rtl/eep_slave.sv
// eep_slave: two-wire serial memory slave, 1024 bytes, 16-byte page buffer
// assumes: scl_in is the master's clock (link domain, stops between frames);
// clk_sys_in runs the self-timed write; sda is open drain with outside pull-up.
//
// Operation
// - eighth address bit one reads, zero writes
// - only top device bit matched to pin
// - acknowledge address only when matched and idle
// - ack address, load word address, ack it
// - stop starts write; no ack until done
// - up to sixteen bytes buffered until stop
// - page write increments four low bits only
// - over sixteen bytes wraps, overwriting earlier ones
// - busy device refuses address, acks when done
// - protect pin: no data ack, no write
// - three read forms with direction bit one
// - counter holds last address plus one
// - read ack then shift one byte out
// - repeated start keeps pointer, accepts read
// - master ack advances address, sends next
// - sequential read wraps at top to zero
// - no ack then stop releases data line
// - start and stop only while clock high
// - write cycle finishes within ten milliseconds
// - two low device bits select block segment
`timescale 1ns/100ps
module eep_slave #(
	parameter int WRITE_CYCLES = eep_pkg::EEP_WRITE_CYC
) (
	// system side
	input  wire logic                  clk_sys_in,
	input  wire logic                  reset_in,
	input  wire logic                  chip_select_bit_high_in,
	input  wire logic                  write_protect_in,
	output logic                       busy_out,
	// two-wire link
	input  wire logic                  scl_in,
	input  wire logic                  sda_in,
	output eep_pkg::eep_sda_drive_s    sda_drive_out
);
	import eep_pkg::*;

	// refuse sizes that the index and pointer slices cannot serve
	generate
		if (WRITE_CYCLES < 1) begin : g_bad_cycles
			$error("WRITE_CYCLES must be at least one");
		end
		if (EEP_PAGE_BYTES != (1 << EEP_PAGE_W)) begin : g_bad_page
			$error("page size must be a power of two");
		end
		if (EEP_MEM_BYTES != (1 << EEP_ADDR_W)) begin : g_bad_mem
			$error("memory size must match the address width");
		end
	endgenerate

	typedef enum logic [5:0] {
		ST_IDLE  = 6'b000001,
		ST_DEV   = 6'b000010,
		ST_WORD  = 6'b000100,
		ST_WDATA = 6'b001000,
		ST_RDATA = 6'b010000,
		ST_DROP  = 6'b100000
	} eep_state_e;

	logic [7:0]            mem [EEP_MEM_BYTES];
	logic [7:0]            page_buf [EEP_PAGE_BYTES];

	// ---------------- link domain (scl) ----------------
	// start/stop seen by sda edges while scl high; sync reset from the start flag only
	logic                  start_flag;
	logic                  stop_flag;
	logic                  start_seen;
	logic                  stop_seen;
	logic                  busy_l1;
	logic                  busy_l2;
	logic                  wp_l1;
	logic                  wp_l2;
	logic                  cs_l1;
	logic                  cs_l2;
	eep_state_e            state;
	logic [3:0]            bit_cnt;
	logic [7:0]            shift;
	logic                  ack_phase;
	logic                  drive_low;
	logic [EEP_ADDR_W-1:0] addr;
	logic [EEP_PAGE_BYTES-1:0] page_mask;
	logic [EEP_ADDR_W-1:0] page_base;
	logic                  wr_armed;
	logic                  commit_tgl;
	eep_commit_s           commit_word;
	logic [7:0]            rd_byte;
	logic                  dev_match;
	logic                  buf_we;

	// sda falling while scl high: start; rising while scl high: stop
	always_ff @(negedge sda_in or posedge reset_in) begin
		if (reset_in)
			start_flag <= 1'b0;
		else if (scl_in)
			start_flag <= ~start_flag;
	end

	always_ff @(posedge sda_in or posedge reset_in) begin
		if (reset_in)
			stop_flag <= 1'b0;
		else if (scl_in)
			stop_flag <= ~stop_flag;
	end

	// toggle tracker in scl domain: a start is pending while the two differ
	logic start_ack_t;
	assign start_seen = start_flag != start_ack_t;

	always_ff @(posedge scl_in or posedge reset_in) begin
		if (reset_in)
			start_ack_t <= 1'b0;
		else if (start_seen)
			start_ack_t <= start_flag;
	end

	// stop is caught in the system domain since scl halts after it
	logic stop_s1;
	logic stop_s2;
	logic stop_s3;

	// write cycle state seen by the link; refuses addresses while high
	always_ff @(posedge scl_in or posedge reset_in) begin
		if (reset_in) begin
			busy_l1 <= 1'b0;
			busy_l2 <= 1'b0;
		end else begin
			busy_l1 <= busy_out;
			busy_l2 <= busy_l1;
		end
	end

	// protect pin, only read through its second stage
	always_ff @(posedge scl_in or posedge reset_in) begin
		if (reset_in) begin
			wp_l1 <= 1'b0;
			wp_l2 <= 1'b0;
		end else begin
			wp_l1 <= write_protect_in;
			wp_l2 <= wp_l1;
		end
	end

	// address-select pin; the control byte gives it eight edges to settle
	always_ff @(posedge scl_in or posedge reset_in) begin
		if (reset_in) begin
			cs_l1 <= 1'b0;
			cs_l2 <= 1'b0;
		end else begin
			cs_l1 <= chip_select_bit_high_in;
			cs_l2 <= cs_l1;
		end
	end

	// receive path: sample sda on rising scl
	always_ff @(posedge scl_in or posedge reset_in) begin
		if (reset_in) begin
			state       <= ST_IDLE;
			bit_cnt     <= 4'h0;
			shift       <= 8'h00;
			ack_phase   <= 1'b0;
			addr        <= EEP_ADDR_RESET;
			page_mask   <= '0;
			page_base   <= EEP_ADDR_RESET;
			wr_armed    <= 1'b0;
		end else if (start_seen) begin
			state       <= ST_DEV;
			bit_cnt     <= 4'h1;
			shift       <= {7'h00, sda_in};
			ack_phase   <= 1'b0;
		end else if (state != ST_IDLE && state != ST_DROP) begin
			if (!ack_phase) begin
				shift   <= {shift[6:0], sda_in};
				bit_cnt <= bit_cnt + 4'h1;
				if (bit_cnt == 4'h7)
					ack_phase <= 1'b1;
			end else begin
				ack_phase <= 1'b0;
				bit_cnt   <= 4'h0;
				unique case (state)
					ST_DEV: begin
						if (dev_match) begin
							addr[9:8] <= shift[2:1];
							if (shift[0]) begin
								state <= ST_RDATA;
							end else begin
								state     <= ST_WORD;
								page_mask <= '0;
								wr_armed  <= 1'b0;
							end
						end else begin
							state <= ST_DROP;
						end
					end
					ST_WORD: begin
						addr[7:0] <= shift;
						page_base <= {addr[9:8], shift[7:4], 4'h0};
						state     <= ST_WDATA;
					end
					ST_WDATA: begin
						if (wp_l2) begin
							state <= ST_DROP;
						end else begin
							page_mask[addr[3:0]] <= 1'b1;
							addr[3:0] <= addr[3:0] + 4'h1;
							wr_armed  <= 1'b1;
						end
					end
					ST_RDATA: begin
						// advance on either answer; master acks with low: send again
						addr <= addr + 10'h001;
						if (sda_in)
							state <= ST_DROP;
					end
					default: state <= ST_DROP;
				endcase
			end
		end
	end

	assign rd_byte = mem[addr];

	// type code and chip bit agree and no write cycle runs
	assign dev_match = shift[7:4] == EEP_TYPE_CODE && shift[3] == cs_l2 && !busy_l2;

	// page buffer has no reset, so it is written in a process of its own
	assign buf_we = !start_seen && state == ST_WDATA && ack_phase && !wp_l2;

	always_ff @(posedge scl_in) begin
		if (buf_we)
			page_buf[addr[3:0]] <= shift;
	end

	// drive path: change sda on falling scl only
	always_ff @(negedge scl_in or posedge reset_in) begin
		if (reset_in) begin
			drive_low <= 1'b0;
		end else if (start_seen || state == ST_IDLE || state == ST_DROP) begin
			drive_low <= 1'b0;
		end else if (state == ST_RDATA) begin
			if (ack_phase)
				drive_low <= 1'b0;
			else
				drive_low <= ~rd_byte[3'd7 - bit_cnt[2:0]];
		end else if (ack_phase) begin
			// ack drawn during the ninth clock
			if (state == ST_DEV)
				drive_low <= dev_match;
			else if (state == ST_WDATA)
				drive_low <= !wp_l2;
			else
				drive_low <= 1'b1;
		end else begin
			drive_low <= 1'b0;
		end
	end

	assign sda_drive_out.sda_out = 1'b0;
	assign sda_drive_out.sda_oe  = drive_low;

	// ---------------- system domain ----------------
	// stop toggle and armed state crossed in; commit data stable while armed
	logic arm_s1;
	logic arm_s2;
	logic [31:0] wcnt;
	logic [EEP_ADDR_W-1:0] wr_addr;
	logic [4:0] wr_idx;

	assign commit_word.base = page_base;
	assign commit_word.mask = page_mask;

	// stop toggle: two stages to settle, a third to find its edge
	always_ff @(posedge clk_sys_in or posedge reset_in) begin
		if (reset_in) begin
			stop_s1 <= 1'b0;
			stop_s2 <= 1'b0;
			stop_s3 <= 1'b0;
		end else begin
			stop_s1 <= stop_flag;
			stop_s2 <= stop_s1;
			stop_s3 <= stop_s2;
		end
	end

	// armed write seen through two stages; page data stands still meanwhile
	always_ff @(posedge clk_sys_in or posedge reset_in) begin
		if (reset_in) begin
			arm_s1 <= 1'b0;
			arm_s2 <= 1'b0;
		end else begin
			arm_s1 <= wr_armed && state == ST_WDATA;
			arm_s2 <= arm_s1;
		end
	end

	assign stop_seen  = stop_s2 != stop_s3;
	assign commit_tgl = stop_seen && arm_s2;

	// self-timed write: copy page then hold busy for the full time
	always_ff @(posedge clk_sys_in or posedge reset_in) begin
		if (reset_in) begin
			busy_out <= 1'b0;
			wcnt     <= 32'h0000_0000;
		end else if (!busy_out) begin
			if (commit_tgl) begin
				busy_out <= 1'b1;
				wcnt     <= 32'h0000_0000;
			end
		end else if (wcnt >= 32'(WRITE_CYCLES - 1)) begin
			busy_out <= 1'b0;
		end else begin
			wcnt <= wcnt + 32'h0000_0001;
		end
	end

	// copy index: walks the page once at the head of each write cycle
	always_ff @(posedge clk_sys_in or posedge reset_in) begin
		if (reset_in)
			wr_idx <= 5'h00;
		else if (!busy_out)
			wr_idx <= 5'h00;
		else if (wr_idx < 5'(EEP_PAGE_BYTES))
			wr_idx <= wr_idx + 5'h01;
	end

	assign wr_addr = {commit_word.base[9:4], wr_idx[3:0]};

	always_ff @(posedge clk_sys_in) begin
		if (busy_out && wr_idx < 5'(EEP_PAGE_BYTES) && commit_word.mask[wr_idx[3:0]])
			mem[wr_addr] <= page_buf[wr_idx[3:0]];
	end
endmodule

// ### tb/eep_master.sv
// eep_master: bus master model that makes the link clock and moves bits
// assumes: the data wire is wired-and with a pull-up, resolved by the bench
`timescale 1ns/100ps
module eep_master (
	// link pins
	output logic      scl_out,
	output logic      sda_out,
	input  wire logic sda_in
);
	localparam int HALF = 32;
	initial begin
		scl_out = 1'b1;
		sda_out = 1'b1;
	end
	// data is set while the clock is low and sampled just before it falls
	task automatic bit_io(input logic b, output logic r);
		sda_out = b;
		#HALF scl_out = 1'b1;
		#HALF r = sda_in;
		scl_out = 1'b0;
	endtask
	task automatic start();
		sda_out = 1'b1;
		#HALF scl_out = 1'b1;
		#HALF sda_out = 1'b0;
		#HALF scl_out = 1'b0;
	endtask
	// the clock then stands high until the next frame
	task automatic stop();
		sda_out = 1'b0;
		#HALF scl_out = 1'b1;
		#HALF sda_out = 1'b1;
		#HALF;
	endtask
	task automatic xfer(input logic [7:0] d, input logic ai, output logic [7:0] q, output logic ao);
		for (int i = 7; i >= 0; i--) bit_io(d[i], q[i]);
		bit_io(ai, ao);
	endtask
endmodule

// ### tb/eep_slave_chk.sv
// eep_slave_chk: timing assertions on the slave's ports
// assumes: bound to the slave; data wire resolved outside
`timescale 1ns/100ps
module eep_slave_chk #(
	parameter int WRITE_CYCLES = 50
) (
	// watched ports
	input wire logic                    clk_sys_in,
	input wire logic                    reset_in,
	input wire logic                    busy_out,
	input wire logic                    scl_in,
	input wire logic                    sda_in,
	input wire eep_pkg::eep_sda_drive_s sda_drive_out
);
	import eep_pkg::*;
	int   cnt;
	logic oe_hi;
	always_ff @(posedge clk_sys_in or posedge reset_in) cnt <= reset_in ? 0 : (busy_out ? cnt + 1 : 0);
	always_ff @(posedge scl_in or posedge reset_in) oe_hi <= reset_in ? 1'b0 : sda_drive_out.sda_oe;
	sequence s_hold;
		busy_out [*8];
	endsequence
	AST_BUSY_HOLDS: assert property (@(posedge clk_sys_in) disable iff (reset_in)
		$rose(busy_out) |-> s_hold) else $error("busy dropped early");
	AST_BUSY_MIN: assert property (@(posedge clk_sys_in) disable iff (reset_in)
		$fell(busy_out) |-> cnt >= WRITE_CYCLES - 2) else $error("write cycle too short");
	AST_BUSY_MAX: assert property (@(posedge clk_sys_in) disable iff (reset_in)
		cnt <= WRITE_CYCLES + 8) else $error("write cycle too long");
	AST_BUSY_QUIET: assert property (@(posedge clk_sys_in) disable iff (reset_in)
		busy_out |-> !sda_drive_out.sda_oe) else $error("drive while busy");
	AST_DRIVE_ZERO: assert property (@(posedge clk_sys_in) disable iff (reset_in)
		!sda_drive_out.sda_out) else $error("data pin driven high");
	AST_LINE_LOW: assert property (@(posedge scl_in) disable iff (reset_in)
		sda_drive_out.sda_oe |-> !sda_in) else $error("driven line not low");
	AST_OE_HOLDS: assert property (@(negedge scl_in) disable iff (reset_in)
		sda_drive_out.sda_oe == oe_hi) else $error("drive changed while clock high");
	AST_START_FREE: assert property (@(negedge sda_in) disable iff (reset_in)
		scl_in |-> !sda_drive_out.sda_oe) else $error("line held at start");
endmodule

// ### tb/testbench.sv
// testbench: drives the slave through the master model and checks replies
// assumes: design and checker compiled first; pull-up resolved here
`timescale 1ns/100ps
module testbench;
	import eep_pkg::*;
	logic           clk_sys_in = 1'b0;
	logic           reset_in = 1'b0;
	logic           cs = 1'b1;
	logic           wp = 1'b0;
	logic           busy, scl, m_sda, k;
	logic [7:0]     q;
	eep_sda_drive_s drv;
	wire            sda = m_sda & ~drv.sda_oe;
	logic [7:0]     ref_mem [0:1023];
	int             miscompares = 0;
	int             total_checks = 0;
	int             cycles = 0;
	always #25 clk_sys_in = ~clk_sys_in;
	eep_slave #(.WRITE_CYCLES(50)) i_dut (.clk_sys_in(clk_sys_in), .reset_in(reset_in),
		.chip_select_bit_high_in(cs), .write_protect_in(wp), .busy_out(busy),
		.scl_in(scl), .sda_in(sda), .sda_drive_out(drv));
	eep_master m (.scl_out(scl), .sda_out(m_sda), .sda_in(sda));
	task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
		total_checks++;
		if (g !== e) begin
			miscompares++;
			$display("ERROR %s exp %h got %h", nm, e, g);
		end
	endtask
	function automatic logic [7:0] cb(input logic [9:0] a, input logic c, input logic r);
		return {EEP_TYPE_CODE, c, a[9:8], r};
	endfunction
	task automatic head(input logic [9:0] a);
		m.start();
		m.xfer(cb(a, cs, 1'b0), 1'b1, q, k);
		chk("addr ack", 8'h00, 8'(k));
		m.xfer(a[7:0], 1'b1, q, k);
		chk("word ack", 8'h00, 8'(k));
	endtask
	task automatic poll(input logic [9:0] a, input logic e);
		m.start();
		m.xfer(cb(a, cs, 1'b0), 1'b1, q, k);
		chk("poll", 8'(e), 8'(k));
		m.stop();
	endtask
	task automatic wr(input logic [9:0] a, input int n, input logic [7:0] v);
		head(a);
		for (int i = 0; i < n; i++) begin
			m.xfer(v + 8'(i), 1'b1, q, k);
			chk("data ack", 8'(wp), 8'(k));
			if (!wp) ref_mem[{a[9:4], a[3:0] + 4'(i)}] = v + 8'(i);
		end
		m.stop();
		repeat (6) @(posedge clk_sys_in);
		chk("busy", 8'(!wp), 8'(busy));
		if (!wp) begin
			poll(a, 1'b1);
			for (int j = 0; j < 200 && busy !== 1'b0; j++) @(posedge clk_sys_in);
			poll(a, 1'b0);
		end
	endtask
	task automatic rd(input logic [9:0] a, input int n);
		head(a);
		m.start();
		m.xfer(cb(a, cs, 1'b1), 1'b1, q, k);
		chk("read ack", 8'h00, 8'(k));
		for (int i = 0; i < n; i++) begin
			m.xfer(8'hFF, i == n - 1, q, k);
			chk("read data", ref_mem[a + 10'(i)], q);
		end
		m.stop();
		chk("released", 8'h00, 8'(drv.sda_oe));
	endtask
	task automatic t_chip();
		poll(10'h000, 1'b0);
		@(posedge clk_sys_in) #1 cs = 1'b0;
		m.start();
		m.xfer(cb(10'h000, 1'b1, 1'b0), 1'b1, q, k);
		chk("chip bit", 8'h01, 8'(k));
		m.stop();
		@(posedge clk_sys_in) #1 cs = 1'b1;
		poll(10'h300, 1'b0);
		$display("t_chip done");
	endtask
	task automatic t_page();
		wr(10'h23C, 18, 8'hA0);
		rd(10'h230, 16);
		$display("t_page done");
	endtask
	task automatic t_cur();
		rd(10'h235, 1);
		m.start();
		m.xfer(cb(10'h200, cs, 1'b1), 1'b1, q, k);
		m.xfer(8'hFF, 1'b1, q, k);
		chk("current read", ref_mem[10'h236], q);
		m.stop();
		$display("t_cur done");
	endtask
	task automatic t_wrap();
		wr(10'h3FF, 1, 8'h5A);
		wr(10'h000, 1, 8'hC3);
		rd(10'h3FF, 2);
		$display("t_wrap done");
	endtask
	task automatic t_wp();
		@(posedge clk_sys_in) #1 wp = 1'b1;
		wr(10'h3FF, 1, 8'h11);
		#1 wp = 1'b0;
		rd(10'h3FF, 1);
		$display("t_wp done");
	endtask
	task automatic close_out();
		$display("checks %0d mismatches %0d", total_checks, miscompares);
		if (miscompares == 0 && total_checks > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask
	always @(posedge clk_sys_in) begin
		cycles++;
		if (cycles == 20000) begin
			miscompares++;
			close_out();
		end
	end
	initial begin
		#1 reset_in = 1'b1;
		repeat (2) @(posedge clk_sys_in);
		#1 reset_in = 1'b0;
		t_chip();
		t_page();
		t_cur();
		t_wrap();
		t_wp();
		close_out();
	end
endmodule
bind eep_slave eep_slave_chk #(.WRITE_CYCLES(WRITE_CYCLES)) i_chk (.clk_sys_in(clk_sys_in),
	.reset_in(reset_in), .busy_out(busy_out), .scl_in(scl_in), .sda_in(sda_in),
	.sda_drive_out(sda_drive_out));
